//--- acp_map.svh
// Character codes, line layout and timing constants of the command parser.
`ifndef ACP_MAP_SVH
`define ACP_MAP_SVH
`define ACP_CH_NODE    8'h4e
`define ACP_CH_READ    8'h54
`define ACP_CH_WRITE   8'h56
`define ACP_CH_CLEAR   8'h52
`define ACP_CH_PRINT   8'h50
`define ACP_CH_STAR    8'h2a
`define ACP_CH_DOLLAR  8'h24
`define ACP_CH_MINUS   8'h2d
`define ACP_CH_DOT     8'h2e
`define ACP_CH_SPACE   8'h20
`define ACP_CH_CR      8'h0d
`define ACP_CH_LF      8'h0a
`define ACP_CH_ZERO    8'h30
`define ACP_CH_NINE    8'h39
`define ACP_ID_INPUT   8'h41
`define ACP_ID_TOTAL   8'h42
`define ACP_ID_MAXV    8'h43
`define ACP_ID_MINV    8'h44
`define ACP_ID_LIMIT1  8'h45
`define ACP_ID_LIMIT2  8'h46
`define ACP_ID_STATUS  8'h4a
`define ACP_ID_GROSS   8'h4c
`define ACP_ID_TARE    8'h51
`define ACP_TAG_INPUT  24'h494e50
`define ACP_TAG_TOTAL  24'h544f54
`define ACP_TAG_MAXV   24'h4d4158
`define ACP_TAG_MINV   24'h4d494e
`define ACP_TAG_LIMIT1 24'h535031
`define ACP_TAG_LIMIT2 24'h535032
`define ACP_TAG_STATUS 24'h435352
`define ACP_TAG_GROSS  24'h475253
`define ACP_TAG_TARE   24'h544152
`define ACP_CSR_OUT1   0
`define ACP_CSR_OUT2   1
`define ACP_CSR_MANUAL 4
`define ACP_IDX_ADDR1  5'h01
`define ACP_IDX_GAP    5'h02
`define ACP_IDX_TAG    5'h03
`define ACP_IDX_FIELD  5'h06
`define ACP_IDX_FLAST  5'h11
`define ACP_IDX_LF     5'h13
`define ACP_IDX_TSP    5'h14
`define ACP_IDX_TCR    5'h15
`define ACP_IDX_TLF    5'h16
`define ACP_CLK_KHZ    25000
`define ACP_SLOW_MS    50
`define ACP_FAST_MS    2
`define ACP_ADDR_DIGS  2'h2
`define ACP_TEN        7'h0a
`endif

//--- acp_pkg.sv
// State types of the command parser.
package acp_pkg;
	typedef enum logic [2:0] {
		ACP_P_START = 3'b000,
		ACP_P_ADDR  = 3'b001,
		ACP_P_ID    = 3'b010,
		ACP_P_DATA  = 3'b011,
		ACP_P_TERM  = 3'b100,
		ACP_P_DROP  = 3'b101
	} acp_parse_type;
	typedef enum logic [2:0] {
		ACP_R_IDLE = 3'b000,
		ACP_R_WAIT = 3'b001,
		ACP_R_SEL  = 3'b010,
		ACP_R_LOAD = 3'b011,
		ACP_R_SEND = 3'b100
	} acp_reply_type;
endpackage : acp_pkg

//--- acp_tx_buf.sv
// Two-entry character buffer between the reply generator and the transmitter.
`timescale 1ns/100ps
module acp_tx_buf (
	// Clock and reset.
	input  wire logic       ref_clk_in,
	input  wire logic       sys_rst_in,
	// Filling side.
	input  wire logic [7:0] in_data_in,
	input  wire logic       in_valid_in,
	output logic            in_ready_out,
	// Draining side.
	output logic [7:0]      out_data_out,
	output logic            out_valid_out,
	input  wire logic       out_ready_in
);
	logic [7:0] s0_reg, s0_next, s1_reg, s1_next;
	logic       v0_reg, v0_next, v1_reg, v1_next;

	assign in_ready_out  = !v1_reg;
	assign out_data_out  = s0_reg;
	assign out_valid_out = v0_reg;

	always_comb
	begin
		s0_next = s0_reg;
		s1_next = s1_reg;
		v0_next = v0_reg;
		v1_next = v1_reg;
		if (v0_reg && out_ready_in)
		begin
			s0_next = s1_reg;
			v0_next = v1_reg;
			v1_next = 1'b0;
		end
		if (in_valid_in && !v1_reg)
		begin
			if (!v0_next)
			begin
				s0_next = in_data_in;
				v0_next = 1'b1;
			end
			else
			begin
				s1_next = in_data_in;
				v1_next = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			s0_reg <= 8'h00;
			s1_reg <= 8'h00;
			v0_reg <= 1'b0;
			v1_reg <= 1'b0;
		end
		else
		begin
			s0_reg <= s0_next;
			s1_reg <= s1_next;
			v0_reg <= v0_next;
			v1_reg <= v1_next;
		end
	end
endmodule : acp_tx_buf

//--- acp_field_fmt.sv
// Builds the twelve-character right-justified value field from decimal digits.
`timescale 1ns/100ps
`include "acp_map.svh"
module acp_field_fmt (
	// Value in decimal digits, digit 0 least significant.
	input  wire logic [39:0] bcd_in,
	input  wire logic        neg_in,
	input  wire logic [2:0]  dec_pos_in,
	// Field, leftmost character in the top byte.
	output logic [95:0]      field_out
);
	always_comb
	begin
		int top;
		int k;
		logic sdone;
		top = 0;
		k = 0;
		sdone = 1'b0;
		field_out = '0;
		for (int i = 0; i < 10; i++)
			if (bcd_in[4*i +: 4] != 4'h0)
				top = i;
		if (int'(dec_pos_in) > top)
			top = int'(dec_pos_in);
		for (int p = 0; p < 12; p++)
		begin
			if (dec_pos_in != 3'h0 && p == int'(dec_pos_in))
				field_out[8*p +: 8] = `ACP_CH_DOT;
			else if (k <= top && k < 10)
			begin
				field_out[8*p +: 8] = `ACP_CH_ZERO | {4'h0, bcd_in[4*k +: 4]};
				k = k + 1;
			end
			else if (neg_in && !sdone)
			begin
				field_out[8*p +: 8] = `ACP_CH_MINUS;
				sdone = 1'b1;
			end
			else
				field_out[8*p +: 8] = `ACP_CH_SPACE;
		end
	end
endmodule : acp_field_fmt

//--- acp_cmd_parser.sv
// Serial command interpreter: parses host strings, executes them, builds replies.
// Behaviour
// - Reply only to read, block print, or local print request.
// - Full line: address, space, three-char tag, twelve-char value, CR LF.
// - Last block line adds space CR LF; single replies omit it.
// - Node address zero sends two spaces instead of address digits.
// - Value field twelve wide, right justified, decimal point, leading minus.
// - Abbreviated line: only value field, then CR and LF.
// - Optional node selector with one or two digits precedes the command.
// - Command letter then one identifier; block print takes no identifier.
// - Write data digits sit between identifier and terminator.
// - Strings end with asterisk or dollar; execution waits for it.
// - Malformed strings are silently dropped, no error reply.
// - Written values keep only the last five digits.
// - Leading zeros ignored; a minus sign marks a negative value.
// - Decimal points in written data are discarded.
// - Writes get no reply.
// - Status bits 0 and 1 show and set the two setpoint outputs.
// - Status bits 5 and 7 always read zero; 2, 3, 6 unused.
// - Status write loads the raw data character code.
// - Reply waits 50 ms after asterisk, 2 ms after dollar.
// - Manual mode outputs follow bits; automatic writes only turn off.
// - Incoming characters are ignored while a reply is pending.
// - Read, write, clear and print letters do their own action.
`timescale 1ns/100ps
`include "acp_map.svh"
module acp_cmd_parser #(
	parameter int unsigned SLOW_CYC = `ACP_SLOW_MS * `ACP_CLK_KHZ,
	parameter int unsigned FAST_CYC = `ACP_FAST_MS * `ACP_CLK_KHZ
) (
	// Clock and reset.
	input  wire logic        ref_clk_in,
	input  wire logic        sys_rst_in,
	// Received characters.
	input  wire logic [7:0]  rx_data_in,
	input  wire logic        rx_valid_in,
	// Transmitted characters.
	output logic [7:0]       tx_data_out,
	output logic             tx_valid_out,
	input  wire logic        tx_ready_in,
	// Configuration.
	input  wire logic [6:0]  node_addr_in,
	input  wire logic        abbrev_in,
	input  wire logic [7:0]  print_mask_in,
	input  wire logic [2:0]  dec_pos_in,
	input  wire logic        print_req_in,
	// Register value lookup.
	output logic [7:0]       value_sel_out,
	input  wire logic [39:0] value_bcd_in,
	input  wire logic        value_neg_in,
	// Write and clear commands.
	output logic             wr_pulse_out,
	output logic [7:0]       wr_sel_out,
	output logic [19:0]      wr_bcd_out,
	output logic             wr_neg_out,
	output logic             clr_pulse_out,
	output logic [7:0]       clr_sel_out,
	// Setpoint outputs.
	input  wire logic [1:0]  sp_trip_in,
	output logic [1:0]       sp_out,
	output logic             manual_out
);
	acp_pkg::acp_parse_type ps_reg, ps_next;
	acp_pkg::acp_reply_type rs_reg, rs_next;
	logic [7:0]  cmd_reg, cmd_next, id_reg, id_next, craw_reg, craw_next;
	logic [6:0]  adr_reg, adr_next;
	logic [1:0]  acnt_reg, acnt_next;
	logic        aseen_reg, aseen_next, neg_reg, neg_next, cgot_reg, cgot_next;
	logic [19:0] bcd_reg, bcd_next;
	logic        go, ok, is_term, is_dig, rx_take;
	logic        x_wr, x_csr, x_clr, x_rep;
	logic [2:0]  perm;
	acp_pkg::acp_parse_type cmd_st;

	function automatic logic [2:0] legal(input logic [7:0] id);
		// Returns read, clear and write permission.
		case (id)
			`ACP_ID_INPUT, `ACP_ID_TOTAL, `ACP_ID_MAXV, `ACP_ID_MINV: legal = 3'b110;
			`ACP_ID_LIMIT1, `ACP_ID_LIMIT2: legal = 3'b111;
			`ACP_ID_STATUS, `ACP_ID_TARE: legal = 3'b101;
			`ACP_ID_GROSS: legal = 3'b100;
			default: legal = 3'b000;
		endcase
	endfunction : legal

	function automatic logic [7:0] blk_id(input logic [2:0] i);
		case (i)
			3'h0: blk_id = `ACP_ID_INPUT;
			3'h1: blk_id = `ACP_ID_TOTAL;
			3'h2: blk_id = `ACP_ID_MAXV;
			3'h3: blk_id = `ACP_ID_MINV;
			3'h4: blk_id = `ACP_ID_LIMIT1;
			3'h5: blk_id = `ACP_ID_LIMIT2;
			3'h6: blk_id = `ACP_ID_GROSS;
			default: blk_id = `ACP_ID_TARE;
		endcase
	endfunction : blk_id

	function automatic logic [23:0] tag(input logic [7:0] id);
		case (id)
			`ACP_ID_INPUT: tag = `ACP_TAG_INPUT;
			`ACP_ID_TOTAL: tag = `ACP_TAG_TOTAL;
			`ACP_ID_MAXV: tag = `ACP_TAG_MAXV;
			`ACP_ID_MINV: tag = `ACP_TAG_MINV;
			`ACP_ID_LIMIT1: tag = `ACP_TAG_LIMIT1;
			`ACP_ID_LIMIT2: tag = `ACP_TAG_LIMIT2;
			`ACP_ID_STATUS: tag = `ACP_TAG_STATUS;
			`ACP_ID_GROSS: tag = `ACP_TAG_GROSS;
			default: tag = `ACP_TAG_TARE;
		endcase
	endfunction : tag

	// A reply in progress blocks the receiver, as the link is half duplex.
	assign rx_take = rx_valid_in && rs_reg == acp_pkg::ACP_R_IDLE;
	assign perm    = legal(rx_data_in);
	assign is_term = rx_data_in == `ACP_CH_STAR || rx_data_in == `ACP_CH_DOLLAR;
	assign is_dig  = rx_data_in >= `ACP_CH_ZERO && rx_data_in <= `ACP_CH_NINE;
	assign cmd_st  = (rx_data_in == `ACP_CH_READ || rx_data_in == `ACP_CH_WRITE
		|| rx_data_in == `ACP_CH_CLEAR) ? acp_pkg::ACP_P_ID
		: rx_data_in == `ACP_CH_PRINT ? acp_pkg::ACP_P_TERM : acp_pkg::ACP_P_DROP;

	always_comb
	begin
		ps_next = ps_reg;
		cmd_next = cmd_reg;
		id_next = id_reg;
		adr_next = adr_reg;
		acnt_next = acnt_reg;
		aseen_next = aseen_reg;
		neg_next = neg_reg;
		bcd_next = bcd_reg;
		craw_next = craw_reg;
		cgot_next = cgot_reg;
		go = 1'b0;
		if (rx_take && is_term)
		begin
			go = ps_reg == acp_pkg::ACP_P_TERM || (ps_reg == acp_pkg::ACP_P_DATA
				&& (id_reg != `ACP_ID_STATUS || cgot_reg));
			ps_next = acp_pkg::ACP_P_START;
			aseen_next = 1'b0;
		end
		else if (rx_take)
		begin
			unique case (ps_reg)
				acp_pkg::ACP_P_START:
					if (rx_data_in == `ACP_CH_NODE)
					begin
						ps_next = acp_pkg::ACP_P_ADDR;
						aseen_next = 1'b1;
						adr_next = 7'h00;
						acnt_next = 2'h0;
					end
					else
					begin
						cmd_next = rx_data_in;
						ps_next = cmd_st;
					end
				acp_pkg::ACP_P_ADDR:
					if (is_dig && acnt_reg != `ACP_ADDR_DIGS)
					begin
						adr_next = 7'(adr_reg * `ACP_TEN + {3'h0, rx_data_in[3:0]});
						acnt_next = acnt_reg + 2'h1;
					end
					else if (acnt_reg == 2'h0)
						ps_next = acp_pkg::ACP_P_DROP;
					else
					begin
						cmd_next = rx_data_in;
						ps_next = cmd_st;
					end
				acp_pkg::ACP_P_ID:
				begin
					id_next = rx_data_in;
					neg_next = 1'b0;
					bcd_next = 20'h00000;
					cgot_next = 1'b0;
					if (!(cmd_reg == `ACP_CH_READ && perm[2])
						&& !(cmd_reg == `ACP_CH_CLEAR && perm[1])
						&& !(cmd_reg == `ACP_CH_WRITE && perm[0]))
						ps_next = acp_pkg::ACP_P_DROP;
					else if (cmd_reg == `ACP_CH_WRITE)
						ps_next = acp_pkg::ACP_P_DATA;
					else
						ps_next = acp_pkg::ACP_P_TERM;
				end
				acp_pkg::ACP_P_DATA:
					if (id_reg == `ACP_ID_STATUS)
					begin
						if (!cgot_reg)
						begin
							craw_next = rx_data_in;
							cgot_next = 1'b1;
						end
						else
							ps_next = acp_pkg::ACP_P_DROP;
					end
					else if (is_dig)
						bcd_next = {bcd_reg[15:0], rx_data_in[3:0]};
					else if (rx_data_in == `ACP_CH_MINUS)
						neg_next = 1'b1;
					else if (rx_data_in != `ACP_CH_DOT)
						ps_next = acp_pkg::ACP_P_DROP;
				acp_pkg::ACP_P_TERM:
					ps_next = acp_pkg::ACP_P_DROP;
				acp_pkg::ACP_P_DROP:
					ps_next = acp_pkg::ACP_P_DROP;
				default:
					ps_next = acp_pkg::ACP_P_DROP;
			endcase
		end
	end

	assign ok    = go && (aseen_reg ? adr_reg == node_addr_in : node_addr_in == 7'h00);
	assign x_wr  = ok && cmd_reg == `ACP_CH_WRITE && id_reg != `ACP_ID_STATUS;
	assign x_csr = ok && cmd_reg == `ACP_CH_WRITE && id_reg == `ACP_ID_STATUS;
	assign x_clr = ok && cmd_reg == `ACP_CH_CLEAR;
	assign x_rep = ok && (cmd_reg == `ACP_CH_READ || cmd_reg == `ACP_CH_PRINT);

	// Command outputs and setpoint state.
	logic        wrp_reg, wrp_next, wneg_reg, wneg_next, clp_reg, clp_next;
	logic        man_reg, man_next;
	logic [1:0]  sp_reg, sp_next;
	logic [7:0]  wsel_reg, wsel_next, csel_reg, csel_next;
	logic [19:0] wbcd_reg, wbcd_next;

	always_comb
	begin
		wrp_next = x_wr;
		wsel_next = x_wr ? id_reg : wsel_reg;
		wbcd_next = x_wr ? bcd_reg : wbcd_reg;
		wneg_next = x_wr ? neg_reg : wneg_reg;
		clp_next = x_clr;
		csel_next = x_clr ? id_reg : csel_reg;
		man_next = man_reg;
		sp_next = sp_reg;
		if (x_clr && id_reg == `ACP_ID_LIMIT1)
			sp_next[`ACP_CSR_OUT1] = 1'b0;
		if (x_clr && id_reg == `ACP_ID_LIMIT2)
			sp_next[`ACP_CSR_OUT2] = 1'b0;
		if (x_csr)
		begin
			man_next = craw_reg[`ACP_CSR_MANUAL];
			if (craw_reg[`ACP_CSR_MANUAL])
				sp_next = craw_reg[1:0];
			else
				sp_next = sp_next & craw_reg[1:0];
		end
		// In automatic mode alarm trips win over a clear in the same cycle so no trip is lost; manual mode ignores them.
		if (!man_next)
			sp_next = sp_next | sp_trip_in;
	end

	// Reply generator.
	logic [20:0] dly_reg, dly_next;
	logic        fast_reg, fast_next, blk_reg, blk_next, last_reg, last_next;
	logic [2:0]  bidx_reg, bidx_next;
	logic [4:0]  idx_reg, idx_next;
	logic [7:0]  sel_reg, sel_next, ch;
	logic [95:0] fld_reg, fld_next, fmt_field;
	logic [39:0] src_bcd;
	logic [4:0]  csr_v;
	logic [23:0] tag_v;
	logic        found, more, buf_ready;
	logic [2:0]  first;

	// Status register view: only bits 0, 1 and 4 are ever non-zero.
	assign csr_v   = {man_reg, 2'b00, sp_reg};
	assign tag_v   = tag(sel_reg);
	assign src_bcd = sel_reg == `ACP_ID_STATUS ? {32'h0, (csr_v >= 5'h0a) ? 4'h1 : 4'h0,
		(csr_v >= 5'h0a) ? 4'(csr_v - 5'h0a) : csr_v[3:0]} : value_bcd_in;

	acp_field_fmt u_fmt (
		.bcd_in     (src_bcd),
		.neg_in     (sel_reg != `ACP_ID_STATUS && value_neg_in),
		.dec_pos_in (sel_reg == `ACP_ID_STATUS ? 3'h0 : dec_pos_in),
		.field_out  (fmt_field)
	);

	always_comb
	begin
		found = 1'b0;
		more = 1'b0;
		first = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (print_mask_in[i] && 3'(i) >= bidx_reg)
			begin
				more = found;
				found = 1'b1;
				first = 3'(i);
			end
		unique case (idx_reg)
			5'h00: ch = node_addr_in == 7'h00 ? `ACP_CH_SPACE
				: `ACP_CH_ZERO | {4'h0, 4'(node_addr_in / `ACP_TEN)};
			`ACP_IDX_ADDR1: ch = node_addr_in == 7'h00 ? `ACP_CH_SPACE
				: `ACP_CH_ZERO | {4'h0, 4'(node_addr_in % `ACP_TEN)};
			`ACP_IDX_GAP, `ACP_IDX_TSP: ch = `ACP_CH_SPACE;
			5'h03, 5'h04, 5'h05: ch = tag_v[8*(5 - int'(idx_reg)) +: 8];
			5'h12, `ACP_IDX_TCR: ch = `ACP_CH_CR;
			`ACP_IDX_LF, `ACP_IDX_TLF: ch = `ACP_CH_LF;
			default: ch = fld_reg[8*(17 - int'(idx_reg)) +: 8];
		endcase
	end

	always_comb
	begin
		rs_next = rs_reg;
		dly_next = dly_reg;
		fast_next = fast_reg;
		blk_next = blk_reg;
		last_next = last_reg;
		bidx_next = bidx_reg;
		idx_next = idx_reg;
		sel_next = sel_reg;
		fld_next = fld_reg;
		unique case (rs_reg)
			acp_pkg::ACP_R_IDLE:
				if (x_rep)
				begin
					rs_next = acp_pkg::ACP_R_WAIT;
					dly_next = 21'h0;
					fast_next = rx_data_in == `ACP_CH_DOLLAR;
					blk_next = cmd_reg == `ACP_CH_PRINT;
					bidx_next = 3'h0;
					sel_next = id_reg;
				end
				else if (print_req_in)
				begin
					rs_next = acp_pkg::ACP_R_SEL;
					blk_next = 1'b1;
					bidx_next = 3'h0;
				end
			acp_pkg::ACP_R_WAIT:
			begin
				dly_next = dly_reg + 21'h1;
				if (dly_reg == (fast_reg ? 21'(FAST_CYC - 1) : 21'(SLOW_CYC - 1)))
					rs_next = acp_pkg::ACP_R_SEL;
			end
			acp_pkg::ACP_R_SEL:
			begin
				last_next = blk_reg && !more;
				rs_next = acp_pkg::ACP_R_LOAD;
				if (blk_reg && !found)
					rs_next = acp_pkg::ACP_R_IDLE;
				else if (blk_reg)
				begin
					sel_next = blk_id(first);
					bidx_next = first;
				end
			end
			acp_pkg::ACP_R_LOAD:
			begin
				fld_next = fmt_field;
				idx_next = abbrev_in ? `ACP_IDX_FIELD : 5'h00;
				rs_next = acp_pkg::ACP_R_SEND;
			end
			acp_pkg::ACP_R_SEND:
				if (buf_ready)
				begin
					idx_next = idx_reg + 5'h1;
					if (idx_reg == (last_reg ? `ACP_IDX_TLF : `ACP_IDX_LF))
					begin
						rs_next = (blk_reg && !last_reg) ? acp_pkg::ACP_R_SEL
							: acp_pkg::ACP_R_IDLE;
						bidx_next = bidx_reg + 3'h1;
					end
				end
			default:
				rs_next = acp_pkg::ACP_R_IDLE;
		endcase
	end

	acp_tx_buf u_buf (
		.ref_clk_in    (ref_clk_in),
		.sys_rst_in    (sys_rst_in),
		.in_data_in    (ch),
		.in_valid_in   (rs_reg == acp_pkg::ACP_R_SEND),
		.in_ready_out  (buf_ready),
		.out_data_out  (tx_data_out),
		.out_valid_out (tx_valid_out),
		.out_ready_in  (tx_ready_in)
	);

	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			ps_reg <= acp_pkg::ACP_P_START;
			cmd_reg <= 8'h00;
			id_reg <= 8'h00;
			craw_reg <= 8'h00;
			adr_reg <= 7'h00;
			acnt_reg <= 2'h0;
			aseen_reg <= 1'b0;
			neg_reg <= 1'b0;
			cgot_reg <= 1'b0;
			bcd_reg <= 20'h00000;
			wrp_reg <= 1'b0;
			wneg_reg <= 1'b0;
			clp_reg <= 1'b0;
			man_reg <= 1'b0;
			sp_reg <= 2'h0;
			wsel_reg <= 8'h00;
			csel_reg <= 8'h00;
			wbcd_reg <= 20'h00000;
			rs_reg <= acp_pkg::ACP_R_IDLE;
			dly_reg <= 21'h0;
			fast_reg <= 1'b0;
			blk_reg <= 1'b0;
			last_reg <= 1'b0;
			bidx_reg <= 3'h0;
			idx_reg <= 5'h00;
			sel_reg <= 8'h00;
			fld_reg <= '0;
		end
		else
		begin
			ps_reg <= ps_next;
			cmd_reg <= cmd_next;
			id_reg <= id_next;
			craw_reg <= craw_next;
			adr_reg <= adr_next;
			acnt_reg <= acnt_next;
			aseen_reg <= aseen_next;
			neg_reg <= neg_next;
			cgot_reg <= cgot_next;
			bcd_reg <= bcd_next;
			wrp_reg <= wrp_next;
			wneg_reg <= wneg_next;
			clp_reg <= clp_next;
			man_reg <= man_next;
			sp_reg <= sp_next;
			wsel_reg <= wsel_next;
			csel_reg <= csel_next;
			wbcd_reg <= wbcd_next;
			rs_reg <= rs_next;
			dly_reg <= dly_next;
			fast_reg <= fast_next;
			blk_reg <= blk_next;
			last_reg <= last_next;
			bidx_reg <= bidx_next;
			idx_reg <= idx_next;
			sel_reg <= sel_next;
			fld_reg <= fld_next;
		end
	end

	assign value_sel_out = sel_reg;
	assign wr_pulse_out  = wrp_reg;
	assign wr_sel_out    = wsel_reg;
	assign wr_bcd_out    = wbcd_reg;
	assign wr_neg_out    = wneg_reg;
	assign clr_pulse_out = clp_reg;
	assign clr_sel_out   = csel_reg;
	assign sp_out        = sp_reg;
	assign manual_out    = man_reg;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_trailer;
		idx_reg == `ACP_IDX_TSP ##[1:300] idx_reg == `ACP_IDX_TCR;
	endsequence
	chk_write_silent: assert property (x_wr && !print_req_in |=> rs_reg == acp_pkg::ACP_R_IDLE)
		else $error("write started a reply");
	chk_busy_ignore: assert property (rs_reg != acp_pkg::ACP_R_IDLE |=> $stable(ps_reg))
		else $error("parser moved during reply");
	chk_term_only: assert property (wrp_reg |-> $past(rx_take && is_term))
		else $error("write executed without terminator");
	chk_wrong_node: assert property (go && aseen_reg && adr_reg != node_addr_in |=> !wrp_reg && !clp_reg)
		else $error("foreign node string acted on");
	chk_delay_fast: assert property ($rose(rs_reg == acp_pkg::ACP_R_SEL) && $past(rs_reg) == acp_pkg::ACP_R_WAIT |-> $past(dly_reg) == (fast_reg ? 21'(FAST_CYC - 1) : 21'(SLOW_CYC - 1)))
		else $error("reply delay count wrong");
	chk_trailer_seq: assert property (rs_reg == acp_pkg::ACP_R_SEND && idx_reg == `ACP_IDX_TSP |-> last_reg && blk_reg ##0 s_trailer)
		else $error("trailer outside last block line");
	chk_zero_addr: assert property (rs_reg == acp_pkg::ACP_R_SEND && idx_reg == 5'h00 && node_addr_in == 7'h00 |-> ch == `ACP_CH_SPACE)
		else $error("address digit sent for node zero");
	chk_abbrev_start: assert property (rs_reg == acp_pkg::ACP_R_LOAD && abbrev_in |=> idx_reg == `ACP_IDX_FIELD)
		else $error("abbreviated line did not start at value");
	chk_manual_follow: assert property (x_csr && craw_reg[`ACP_CSR_MANUAL] |=> sp_reg == $past(craw_reg[1:0]) && man_reg)
		else $error("manual write not followed");
	chk_auto_off: assert property (x_csr && !craw_reg[`ACP_CSR_MANUAL] |=> (sp_reg & ~$past(sp_reg) & ~$past(sp_trip_in)) == 2'h0)
		else $error("automatic write turned an output on");
	chk_five_digits: assert property (x_wr |=> wr_bcd_out == $past(bcd_reg))
		else $error("write digits not the last five");
endmodule : acp_cmd_parser

//--- acp_host_sink.sv
// Transmitter side model: takes reply characters and can stall.
`timescale 1ns/100ps
module acp_host_sink (
	// Clock and reset.
	input  wire logic       ref_clk_in,
	input  wire logic       sys_rst_in,
	// Reply characters.
	input  wire logic [7:0] tx_data_in,
	input  wire logic       tx_valid_in,
	output logic            tx_ready_out,
	// Stall every other cycle when high.
	input  wire logic       stall_in
);
	logic [7:0] got[$];
	logic       ph;
	// A slow line is modelled by refusing on alternate cycles.
	assign tx_ready_out = ~stall_in | ph;
	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			ph <= 1'b0;
		else
		begin
			ph <= ~ph;
			if (tx_valid_in && tx_ready_out)
				got.push_back(tx_data_in);
		end
	end
endmodule : acp_host_sink

//--- ascii_serial_command_parser_tb.sv
// Self-checking testbench of the command parser.
`timescale 1ns/100ps
module ascii_serial_command_parser_tb;
	logic        ref_clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        rx_valid   = 1'b0;
	logic        abbrev     = 1'b0;
	logic        stall      = 1'b0;
	logic        preq       = 1'b0;
	logic [1:0]  trip       = 2'h0;
	logic        rdy;
	logic        txv;
	logic        wp;
	logic        wn;
	logic        cp;
	logic        man;
	logic [7:0]  rx_data    = 8'h00;
	logic [7:0]  mask       = 8'h00;
	logic [7:0]  txd;
	logic [7:0]  vsel;
	logic [7:0]  ws;
	logic [7:0]  cs;
	logic [6:0]  node       = 7'h00;
	logic [2:0]  dec        = 3'h0;
	logic [1:0]  sp;
	logic [19:0] wb;
	logic [39:0] bcd;
	int          n_mismatch = 0;
	int          n_checks   = 0;
	always #20 ref_clk_in = ~ref_clk_in;
	assign bcd = (vsel == 8'h46) ? 40'h0000002505 : 40'h0000000875;
	acp_cmd_parser #(.SLOW_CYC(20), .FAST_CYC(5)) i_acp_cmd_parser (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.rx_data_in(rx_data), .rx_valid_in(rx_valid),
		.tx_data_out(txd), .tx_valid_out(txv), .tx_ready_in(rdy),
		.node_addr_in(node), .abbrev_in(abbrev), .print_mask_in(mask),
		.dec_pos_in(dec), .print_req_in(preq), .value_sel_out(vsel),
		.value_bcd_in(bcd), .value_neg_in(vsel == 8'h46),
		.wr_pulse_out(wp), .wr_sel_out(ws), .wr_bcd_out(wb), .wr_neg_out(wn),
		.clr_pulse_out(cp), .clr_sel_out(cs),
		.sp_trip_in(trip), .sp_out(sp), .manual_out(man));
	acp_host_sink i_acp_host_sink (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .tx_data_in(txd),
		.tx_valid_in(txv), .tx_ready_out(rdy), .stall_in(stall));
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	task check(input logic [39:0] got, input logic [39:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t saw %h expected %h", $time, got, exp);
		end
	endtask : check
	// Characters go in back to back; the pulses are sampled just after the terminator edge.
	task send(input string s);
		@(posedge ref_clk_in);
		for (int i = 0; i < s.len(); i++)
		begin
			rx_data  <= s[i];
			rx_valid <= 1'b1;
			@(posedge ref_clk_in);
		end
		rx_valid <= 1'b0;
		#1;
	endtask : send
	// The settle wait exceeds the slow reply delay so a stray reply is seen.
	task rep(input string e);
		int k;
		for (k = 0; k < 600 && i_acp_host_sink.got.size() < e.len(); k++)
			@(posedge ref_clk_in);
		if (k == 600)
		begin
			n_mismatch++;
			print_verdict;
		end
		repeat (30) @(posedge ref_clk_in);
		check(40'(i_acp_host_sink.got.size()), 40'(e.len()));
		for (int j = 0; j < e.len(); j++)
			check(i_acp_host_sink.got[j], e[j]);
		i_acp_host_sink.got.delete();
	endtask : rep
	initial
	begin
		repeat (20) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		send("VE12*");
		check(wp, 1'b1);
		check({ws, wb}, {8'h45, 20'h00012});
		rep("");
		send("VF-0123.456$");
		check(wb, 20'h23456);
		check(wn, 1'b1);
		send("TA*");
		send("VE9$");
		check({wp, ws}, {1'b0, 8'h46});
		check(40'(i_acp_host_sink.got.size()), 40'h0);
		rep("   INP         875\015\012");
		send("X*");
		rep("");
		send("VJ3*");
		check({man, sp}, {1'b1, 2'h3});
		send("VJ!*");
		check({man, sp}, {1'b0, 2'h1});
		send("RE$");
		check({cp, cs, sp}, {1'b1, 8'h45, 2'h0});
		send("VJ3*");
		@(posedge ref_clk_in);
		abbrev <= 1'b1;
		send("TJ$");
		rep("          19\015\012");
		@(posedge ref_clk_in);
		dec   <= 3'h1;
		mask  <= 8'h21;
		stall <= 1'b1;
		send("P*");
		rep("        87.5\015\012      -250.5\015\012 \015\012");
		@(posedge ref_clk_in);
		abbrev <= 1'b0;
		node   <= 7'h11;
		stall  <= 1'b0;
		send("N5TA$");
		rep("");
		send("N17TA$");
		rep("17 INP        87.5\015\012");
		send("N17VJ@*");
		check({man, sp}, {1'b0, 2'h0});
		@(posedge ref_clk_in);
		trip <= 2'h2;
		@(posedge ref_clk_in);
		trip <= 2'h0;
		#1;
		check(sp, 2'h2);
		send("N17RF$");
		check({cp, cs, sp}, {1'b1, 8'h46, 2'h0});
		@(posedge ref_clk_in);
		mask <= 8'h01;
		preq <= 1'b1;
		@(posedge ref_clk_in);
		preq <= 1'b0;
		rep("17 INP        87.5\015\012 \015\012");
		print_verdict;
	end
endmodule : ascii_serial_command_parser_tb
